// >>> pnvm_bus_model.sv
/* Shared data bus between programmer and port.
   Assumes the programmer releases before output enable. */
`timescale 1ns/1ps
`default_nettype none
module pnvm_bus_model (
  input wire logic clk,
  input wire logic progOe,
  input wire logic [7:0] progData,
  input wire logic dataOe,
  input wire logic [7:0] dataOut,
  output logic [7:0] busLevel
);
  logic [7:0] last_q;
  always @(posedge clk)
    last_q <= busLevel;
  // Released bus inverts each cycle, so a stale value is never held
  always_comb busLevel = dataOe ? dataOut : (progOe ? progData : ~last_q);
endmodule // pnvm_bus_model
`default_nettype wire

// >>> pnvm_edge.v
/*
  Rising/falling edge detector for one strobe input.
  Assumes the input is already synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module pnvm_edge (
  input wire clk,
  input wire srst,
  input wire sig,
  output wire rise,
  output wire fall
);
  reg sig_q;
  always @(posedge clk)
  begin
    if (srst)
      sig_q <= 1'b0;
    else
      sig_q <= sig;
  end
  assign rise = sig & ~sig_q;
  assign fall = ~sig & sig_q;
endmodule // pnvm_edge
`default_nettype wire

// >>> pnvm_map.vh
/*
  Constants for the parallel program port: action codes, commands,
  byte-select codes and timing counts.
  Assumes a 250 MHz system clock.
*/
`ifndef PNVM_MAP_VH
`define PNVM_MAP_VH
`define PNVM_ACT_ADDR 2'h0
`define PNVM_ACT_DATA 2'h1
`define PNVM_ACT_CMD 2'h2
`define PNVM_ACT_IDLE 2'h3
`define PNVM_CMD_NOP 8'h00
`define PNVM_CMD_ERASE 8'h80
`define PNVM_CMD_WFUSE 8'h40
`define PNVM_CMD_WLOCK 8'h20
`define PNVM_CMD_WPROG 8'h10
`define PNVM_CMD_WDATA 8'h11
`define PNVM_CMD_RSIG 8'h08
`define PNVM_CMD_RFUSE 8'h04
`define PNVM_CMD_RPROG 8'h02
`define PNVM_CMD_RDATA 8'h03
`define PNVM_BS_LOW 2'h0
`define PNVM_BS_HIGH 2'h1
`define PNVM_BS_EXT 2'h2
`define PNVM_BS_FHIGH 2'h3
`define PNVM_CLK_MHZ 250
`define PNVM_WRITE_TIME_US 3700
`define PNVM_WRITE_CYCLES (`PNVM_WRITE_TIME_US * `PNVM_CLK_MHZ)
`define PNVM_FUSE_LOW_RST 8'hFF
`define PNVM_FUSE_HIGH_RST 8'hFF
`define PNVM_FUSE_EXT_RST 8'hFF
`define PNVM_LOCK_RST 8'hFF
`define PNVM_LOCK_BOOT_MASK 8'h3C
`endif

// >>> pnvm_monitor.sv
/* Checker for the program port, bound to its ports.
   Assumes pins held >=2 cycles and one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module pnvm_monitor #(parameter WRITE_CYCLES = 50, parameter [7:0] ID0 = 8'h00)(
  input wire logic clk,
  input wire logic srst,
  input wire logic load_strobe,
  input wire logic action_select_msb,
  input wire logic action_select_lsb,
  input wire logic byte_select_one,
  input wire logic byte_select_two,
  input wire logic writeStrobe_n,
  input wire logic outputEnable_n,
  input wire logic [7:0] dataIn,
  input wire logic [7:0] dataOut,
  input wire logic dataOe,
  input wire logic completion_flag,
  input wire logic [7:0] lockBits
);
  logic [1:0] lsH;
  logic [7:0] cmdQ, adrQ;
  logic [31:0] bCnt;
  wire [1:0] act = {action_select_msb, action_select_lsb};
  wire [1:0] sel = {byte_select_two, byte_select_one};
  wire wrCmd = cmdQ inside {8'h10, 8'h11, 8'h40, 8'h20, 8'h80};
  // Load seen one edge later than the port, which acts on the first edge
  always @(posedge clk)
  begin
    lsH <= {lsH[0], load_strobe};
    bCnt <= completion_flag ? 32'h0000_0000 : bCnt + 32'h0000_0001;
    if (srst)
      {cmdQ, adrQ} <= 16'h0000;
    else if (lsH == 2'b01 && act == 2'h2)
      cmdQ <= dataIn;
    else if (lsH == 2'b01 && act == 2'h0 && sel == 2'h0)
      adrQ <= dataIn;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  AST_OE: assert property (dataOe == !outputEnable_n) else $error("bus drive wrong");
  AST_GO: assert property ($fell(writeStrobe_n) && completion_flag && wrCmd |-> ##[1:2] !completion_flag)
    else $error("write did not start");
  AST_IGN: assert property ($fell(writeStrobe_n) && !wrCmd |-> ##1 completion_flag [*3])
    else $error("write without command");
  AST_LEN: assert property (!completion_flag |-> bCnt < WRITE_CYCLES) else $error("busy too long");
  AST_END: assert property ($rose(completion_flag) |-> bCnt == WRITE_CYCLES)
    else $error("busy length wrong");
  AST_STICK: assert property (cmdQ != 8'h80 |-> (~$past(lockBits) & lockBits) == 8'h00)
    else $error("lock bit cleared");
  AST_BOOT: assert property ($past(lockBits[1:0]) == 2'h0 && cmdQ != 8'h80 |-> $stable(lockBits[5:2]))
    else $error("boot lock changed");
  AST_LRD: assert property ((cmdQ == 8'h04 && sel == 2'h1 && !outputEnable_n) [*3] |-> dataOut == lockBits)
    else $error("lock read wrong");
  AST_SIG: assert property ((cmdQ == 8'h08 && adrQ == 8'h00 && !byte_select_one && !outputEnable_n) [*3]
    |-> dataOut == ID0) else $error("id read wrong");
  C_BUSY: cover property ($rose(completion_flag));
  C_LRD: cover property (cmdQ == 8'h04 && sel == 2'h1 && !outputEnable_n);
  C_SIG: cover property (cmdQ == 8'h08 && !outputEnable_n);
  C_ERASE: cover property (cmdQ == 8'h80 && !completion_flag);
endmodule // pnvm_monitor
bind pnvm_program_port pnvm_monitor #(.WRITE_CYCLES(WRITE_CYCLES), .ID0(ID0)) uMon (.*);
`default_nettype wire

// >>> pnvm_program_port.v
/*
  Device-side logic of the parallel program port: loads, page buffers,
  memory arrays, fuse/lock storage and read-back.
  Assumes programmer strobes are synchronous to clk and held several cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pnvm_map.vh"
module pnvm_program_port #(
  parameter PAGE_BITS = 6,
  parameter PROG_ADDR_BITS = 10,
  parameter DATA_PAGE_BITS = 2,
  parameter DATA_ADDR_BITS = 9,
  parameter WRITE_CYCLES = `PNVM_WRITE_CYCLES,
  parameter [7:0] ID0 = 8'h5A,
  parameter [7:0] ID1 = 8'hA5,
  parameter [7:0] ID2 = 8'h3C
)(
  input wire clk,
  input wire srst,
  input wire load_strobe,
  input wire action_select_msb,
  input wire action_select_lsb,
  input wire byte_select_one,
  input wire byte_select_two,
  input wire page_latch_strobe,
  input wire writeStrobe_n,
  input wire outputEnable_n,
  input wire [7:0] dataIn,
  output reg [7:0] dataOut,
  output wire dataOe,
  output wire completion_flag,
  output wire [7:0] lockBits
);
  // ID values are arbitrary
  localparam ST_IDLE = 2'b01;
  localparam ST_BUSY = 2'b10;
  localparam PW = 1 << PAGE_BITS;
  localparam DPW = 1 << DATA_PAGE_BITS;

  wire loadRise;
  wire wrFall;
  wire plRise;
  wire [1:0] action = {action_select_msb, action_select_lsb};
  wire [1:0] bsel = {byte_select_two, byte_select_one};

  // Edges are seen in the same cycle, so strobes need hold only one cycle
  pnvm_edge uLoad (.clk(clk), .srst(srst), .sig(load_strobe), .rise(loadRise), .fall());
  pnvm_edge uWr (.clk(clk), .srst(srst), .sig(~writeStrobe_n), .rise(wrFall), .fall());
  pnvm_edge uPl (.clk(clk), .srst(srst), .sig(page_latch_strobe), .rise(plRise), .fall());

  reg [7:0] cmd_q;
  reg [23:0] addr_q;
  reg [7:0] dataLo_q;
  reg [7:0] dataHi_q;
  reg [7:0] fuseLo_q;
  reg [7:0] fuseHi_q;
  reg [7:0] fuseExt_q;
  reg [7:0] lock_q;
  reg [1:0] state_q;
  reg [31:0] cnt_q;
  reg wrEn_q;
  reg [15:0] progPage [0:PW-1];
  reg [7:0] dataPage [0:DPW-1];
  reg [15:0] progMem [0:(1<<PROG_ADDR_BITS)-1];
  reg [7:0] dataMem [0:(1<<DATA_ADDR_BITS)-1];
  reg [1:0] pendOp_q;
  reg [PROG_ADDR_BITS-1:0] pageBase_q;
  reg [DATA_ADDR_BITS-1:0] dPageBase_q;
  reg [PAGE_BITS:0] copyIdx_q;

  function isWriteCmd;
    input [7:0] c;
    begin
      isWriteCmd = (c == `PNVM_CMD_WPROG) || (c == `PNVM_CMD_WDATA) ||
        (c == `PNVM_CMD_WFUSE) || (c == `PNVM_CMD_WLOCK) || (c == `PNVM_CMD_ERASE);
    end
  endfunction

  // Addresses past the last id byte read as zero
  function [7:0] idByte;
    input [7:0] a;
    begin
      case (a)
        8'h00: idByte = ID0;
        8'h01: idByte = ID1;
        8'h02: idByte = ID2;
        default: idByte = 8'h00;
      endcase
    end
  endfunction

  wire busy = (state_q == ST_BUSY);
  wire startWr = wrFall && !busy && wrEn_q && isWriteCmd(cmd_q);
  wire [PROG_ADDR_BITS-1:0] progAddr = addr_q[PROG_ADDR_BITS-1:0];
  wire [DATA_ADDR_BITS-1:0] dataAddr = addr_q[DATA_ADDR_BITS-1:0];
  wire lockMode3 = (lock_q[1:0] == 2'b00);
  // Boot lock bits refused in mode 3, and zeros accumulate until an erase restores all ones
  wire [7:0] lockReq = lockMode3 ? (dataLo_q | `PNVM_LOCK_BOOT_MASK) : dataLo_q;
  integer i;
  integer j;

  always @(posedge clk)
  begin
    if (srst)
    begin
      cmd_q <= `PNVM_CMD_NOP;
      addr_q <= 24'h00_0000;
      dataLo_q <= 8'h00;
      dataHi_q <= 8'h00;
      wrEn_q <= 1'b0;
    end
    else if (loadRise)
    begin
      case (action)
        `PNVM_ACT_ADDR:
        begin
          case (bsel)
            `PNVM_BS_LOW: addr_q[7:0] <= dataIn;
            `PNVM_BS_HIGH: addr_q[15:8] <= dataIn;
            `PNVM_BS_EXT: addr_q[23:16] <= dataIn;
            default: addr_q <= addr_q;
          endcase
        end
        `PNVM_ACT_DATA:
        begin
          if (byte_select_one)
            dataHi_q <= dataIn;
          else
            dataLo_q <= dataIn;
        end
        `PNVM_ACT_CMD:
        begin
          cmd_q <= dataIn;
          wrEn_q <= (dataIn != `PNVM_CMD_NOP);
        end
        default: cmd_q <= cmd_q;
      endcase
    end
  end

  // Page buffer latch; copied words go back to erased so a later
  // page never programs stale words left from an earlier one
  always @(posedge clk)
  begin
    if (srst)
    begin
      for (j = 0; j < PW; j = j + 1)
        progPage[j] <= 16'hFFFF;
      for (j = 0; j < DPW; j = j + 1)
        dataPage[j] <= 8'hFF;
    end
    else if (plRise && !busy)
    begin
      if (cmd_q == `PNVM_CMD_WDATA)
        dataPage[addr_q[DATA_PAGE_BITS-1:0]] <= dataLo_q;
      else
        progPage[addr_q[PAGE_BITS-1:0]] <= {dataHi_q, dataLo_q};
    end
    else if (busy && !copyIdx_q[PAGE_BITS])
    begin
      if (pendOp_q == 2'b01)
        progPage[copyIdx_q[PAGE_BITS-1:0]] <= 16'hFFFF;
      if (pendOp_q == 2'b10 && copyIdx_q[PAGE_BITS-1:0] < DPW)
        dataPage[copyIdx_q[DATA_PAGE_BITS-1:0]] <= 8'hFF;
    end
  end

  // Programming sequencer; page copy runs inside the busy window
  always @(posedge clk)
  begin
    if (srst)
    begin
      state_q <= ST_IDLE;
      cnt_q <= 32'h0000_0000;
      fuseLo_q <= `PNVM_FUSE_LOW_RST;
      fuseHi_q <= `PNVM_FUSE_HIGH_RST;
      fuseExt_q <= `PNVM_FUSE_EXT_RST;
      lock_q <= `PNVM_LOCK_RST;
      pendOp_q <= 2'b00;
      pageBase_q <= {PROG_ADDR_BITS{1'b0}};
      dPageBase_q <= {DATA_ADDR_BITS{1'b0}};
      copyIdx_q <= {(PAGE_BITS+1){1'b0}};
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (startWr)
          begin
            state_q <= ST_BUSY;
            cnt_q <= WRITE_CYCLES - 1;
            copyIdx_q <= {(PAGE_BITS+1){1'b0}};
            pageBase_q <= {progAddr[PROG_ADDR_BITS-1:PAGE_BITS], {PAGE_BITS{1'b0}}};
            dPageBase_q <= {dataAddr[DATA_ADDR_BITS-1:DATA_PAGE_BITS], {DATA_PAGE_BITS{1'b0}}};
            pendOp_q <= 2'b00;
            case (cmd_q)
              `PNVM_CMD_WPROG: if (bsel == `PNVM_BS_LOW) pendOp_q <= 2'b01;
              `PNVM_CMD_WDATA: if (bsel == `PNVM_BS_LOW) pendOp_q <= 2'b10;
              `PNVM_CMD_WFUSE:
              begin
                if (bsel == `PNVM_BS_LOW)
                  fuseLo_q <= dataLo_q;
                else if (bsel == `PNVM_BS_HIGH)
                  fuseHi_q <= dataLo_q;
                else if (bsel == `PNVM_BS_EXT)
                  fuseExt_q <= dataLo_q;
              end
              `PNVM_CMD_WLOCK: lock_q <= lock_q & lockReq;
              `PNVM_CMD_ERASE:
              begin
                lock_q <= `PNVM_LOCK_RST;
                pendOp_q <= 2'b11;
              end
              default: pendOp_q <= 2'b00;
            endcase
          end
        end
        ST_BUSY:
        begin
          if (!copyIdx_q[PAGE_BITS])
            copyIdx_q <= copyIdx_q + 1'b1;
          // Busy never ends before the page copy, even with a short write time
          if (cnt_q != 32'h0000_0000)
            cnt_q <= cnt_q - 1'b1;
          else if (copyIdx_q[PAGE_BITS])
            state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Array writes during busy: buffer copies and page erase
  wire [PAGE_BITS-1:0] ci = copyIdx_q[PAGE_BITS-1:0];
  always @(posedge clk)
  begin
    if (busy && !copyIdx_q[PAGE_BITS])
    begin
      if (pendOp_q == 2'b01)
        progMem[pageBase_q | ci] <= progPage[ci];
      if (pendOp_q == 2'b10 && ci < DPW)
        dataMem[dPageBase_q | ci[DATA_PAGE_BITS-1:0]] <= dataPage[ci[DATA_PAGE_BITS-1:0]];
    end
    if (busy && pendOp_q == 2'b11)
    begin
      for (i = 0; i < PW; i = i + 1)
        progMem[pageBase_q | i[PAGE_BITS-1:0]] <= 16'hFFFF;
    end
  end

  // Read-back mux, registered
  always @(posedge clk)
  begin
    if (srst)
      dataOut <= 8'h00;
    else
    begin
      case (cmd_q)
        `PNVM_CMD_RPROG: dataOut <= byte_select_one ? progMem[progAddr][15:8] : progMem[progAddr][7:0];
        `PNVM_CMD_RDATA: dataOut <= dataMem[dataAddr];
        `PNVM_CMD_RFUSE:
        begin
          case (bsel)
            `PNVM_BS_LOW: dataOut <= fuseLo_q;
            `PNVM_BS_HIGH: dataOut <= lock_q;
            `PNVM_BS_EXT: dataOut <= fuseExt_q;
            default: dataOut <= fuseHi_q;
          endcase
        end
        `PNVM_CMD_RSIG: dataOut <= idByte(addr_q[7:0]);
        default: dataOut <= 8'h00;
      endcase
    end
  end

  assign dataOe = ~outputEnable_n & ~srst;
  assign completion_flag = ~busy;
  assign lockBits = lock_q;
endmodule // pnvm_program_port
`default_nettype wire

// >>> pnvm_program_port_test.sv
/* Self-checking bench for the program port.
   Assumes a short write time parameter and the bus model. */
`timescale 1ns/1ps
`default_nettype none
module pnvm_program_port_test;
  localparam int WC = 80;
  localparam logic [7:0] SIG [3] = '{8'h12, 8'h34, 8'h56}; // Arbitrary id values
  logic clk = 1'b0, srst, ls, pl, wrN, oeN, pOe, cf, dOe;
  logic [1:0] act, bs;
  logic [7:0] pd, bus, dOut, lk, lkE, d, hiD;
  logic [7:0] f [3];
  logic [15:0] w [4];
  logic [5:0] wix;
  int nErrors = 0, checksDone = 0, i, k;
  always #2 clk = ~clk;
  pnvm_program_port #(.WRITE_CYCLES(WC), .ID0(SIG[0]), .ID1(SIG[1]), .ID2(SIG[2])) DUT (
    .clk(clk), .srst(srst), .load_strobe(ls), .action_select_msb(act[1]), .action_select_lsb(act[0]),
    .byte_select_one(bs[0]), .byte_select_two(bs[1]), .page_latch_strobe(pl), .writeStrobe_n(wrN),
    .outputEnable_n(oeN), .dataIn(bus), .dataOut(dOut), .dataOe(dOe), .completion_flag(cf), .lockBits(lk));
  pnvm_bus_model bm (.clk(clk), .progOe(pOe), .progData(pd), .dataOe(dOe), .dataOut(dOut), .busLevel(bus));
  function automatic logic [7:0] lockExp(input logic [7:0] o, n);
    lockExp = o & n;
    if (o[1:0] == 2'h0)
      lockExp[5:2] = o[5:2];
  endfunction
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [7:0] got, exp);
    checksDone++;
    nErrors += (got !== exp);
    if (got !== exp)
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
  endtask
  task automatic ld(input logic [1:0] a, s, input logic [7:0] v);
    {act, bs, pd, ls} = {a, s, v, 1'b1};
    tick(3);
    ls = 1'b0;
    tick(3);
  endtask
  task automatic latch();
    pl = 1'b1;
    tick(3);
    pl = 1'b0;
    tick(3);
  endtask
  task automatic rd(input logic [1:0] s, input logic [7:0] e);
    {pOe, oeN, bs} = {2'b00, s};
    tick(3);
    chk(bus, e);
    oeN = 1'b1;
    tick(1);
    chk({7'h00, dOe}, 8'h00);
    pOe = 1'b1;
    tick(1);
  endtask
  // Second pulse lands inside busy and must not restart it
  task automatic wr(input logic [1:0] s, input logic [7:0] e);
    bs = s;
    tick(2);
    repeat (2)
    begin
      wrN = 1'b0;
      tick(3);
      wrN = 1'b1;
      tick(3);
    end
    chk({7'h00, cf}, e);
    repeat (WC + 9) if (cf !== 1'b1) tick(1);
    chk({7'h00, cf}, 8'h01);
    bs = 2'h0;
    tick(1);
  endtask
  task automatic reportAndStop();
    $display("errors %0d checks %0d", nErrors, checksDone);
    if (nErrors == 0 && checksDone > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    nErrors++;
    reportAndStop();
  end
  initial
  begin
    {srst, ls, act, bs, pl, wrN, oeN, pd, pOe} = {1'b1, 1'b0, 4'h0, 3'h3, 8'h00, 1'b1};
    void'($urandom(32'h247a));
    tick(6);
    srst = 1'b0;
    tick(2);
    chk({6'h00, cf, dOe}, 8'h02);
    chk(lk, 8'hFF);
    ld(2'h2, 2'h0, 8'h40);
    for (i = 0; i < 3; i++)
    begin
      f[i] = 8'($urandom);
      ld(2'h1, 2'h0, f[i]);
      wr(i[1:0], 8'h00);
    end
    ld(2'h2, 2'h0, 8'h04);
    rd(2'h0, f[0]);
    rd(2'h3, f[1]);
    rd(2'h2, f[2]);
    ld(2'h2, 2'h0, 8'h00);
    wr(2'h0, 8'h01);
    ld(2'h2, 2'h0, 8'h20);
    lkE = 8'hFF;
    for (i = 0; i < 3; i++)
    begin
      d = (i == 0) ? 8'hFC : 8'($urandom);
      ld(2'h1, 2'h0, d);
      wr(2'h0, 8'h00);
      lkE = lockExp(lkE, d);
      chk(lk, lkE);
    end
    ld(2'h2, 2'h0, 8'h04);
    rd(2'h1, lkE);
    wix = 6'($urandom);
    ld(2'h2, 2'h0, 8'h10);
    ld(2'h0, 2'h1, 8'h00);
    ld(2'h0, 2'h2, 8'h00);
    for (i = 0; i < 4; i++)
    begin
      w[i] = 16'($urandom);
      ld(2'h0, 2'h0, {i[1], 1'b0, wix ^ {5'h00, i[0]}});
      ld(2'h1, 2'h0, w[i][7:0]);
      ld(2'h1, 2'h1, w[i][15:8]);
      latch();
      if (i[0])
        wr(2'h0, 8'h00);
    end
    ld(2'h2, 2'h0, 8'h00);
    ld(2'h2, 2'h0, 8'h02);
    for (i = 0; i < 4; i++)
    begin
      ld(2'h0, 2'h0, {i[1], 1'b0, wix ^ {5'h00, i[0]}});
      rd(2'h0, w[i][7:0]);
      rd(2'h1, w[i][15:8]);
      rd(2'h0, w[i][7:0]);
    end
    hiD = {7'h00, wix[0]};
    ld(2'h2, 2'h0, 8'h11);
    ld(2'h0, 2'h1, hiD);
    for (k = 0; k < 4; k++)
    begin
      ld(2'h0, 2'h0, {wix, k[1:0]});
      ld(2'h1, 2'h0, w[k][15:8]);
      latch();
    end
    wr(2'h0, 8'h00);
    ld(2'h2, 2'h0, 8'h03);
    for (k = 0; k < 4; k++)
    begin
      ld(2'h0, 2'h0, {wix, k[1:0]});
      rd(2'h0, w[k][15:8]);
    end
    ld(2'h2, 2'h0, 8'h08);
    for (k = 0; k < 3; k++)
    begin
      ld(2'h0, 2'h0, k[7:0]);
      rd(2'h0, SIG[k]);
    end
    ld(2'h3, 2'h0, 8'h04);
    rd(2'h0, SIG[2]);
    ld(2'h0, 2'h1, 8'h00);
    ld(2'h2, 2'h0, 8'h02);
    ld(2'h0, 2'h0, {2'b10, wix ^ 6'h02});
    rd(2'h0, 8'hFF);
    ld(2'h0, 2'h0, {2'b00, wix});
    ld(2'h2, 2'h0, 8'h80);
    wr(2'h0, 8'h00);
    chk(lk, 8'hFF);
    ld(2'h2, 2'h0, 8'h02);
    rd(2'h1, 8'hFF);
    reportAndStop();
  end
endmodule // pnvm_program_port_test
`default_nettype wire
